//--- core/cfg_regs_defs.svh
`ifndef CFG_REGS_DEFS_SVH
`define CFG_REGS_DEFS_SVH

// register byte offsets
`define OFS_MODE 12'h300
`define OFS_IDENT 12'h304
`define OFS_SCRATCH 12'h308
`define OFS_SWRST 12'h30C

// mode control field positions
`define MODE_XCVR_RST 31
`define MODE_OC_TYPE 15
`define MODE_BUS_WIDTH 8
`define MODE_ACK_POL 6
`define MODE_REQ_POL 5
`define MODE_ALERT_POL 2
`define MODE_ALERT_STYLE 1
`define MODE_ALERT_GATE 0

// software reset field positions
`define SWRST_CTRL 1
`define SWRST_ALL 0

// reset values
`define MODE_RESET 32'h0000_0100
`define SCRATCH_RESET 32'h0000_0000
`define SWRST_RESET 32'h0000_0000

// alert pulse width in ns and its cycle count at 10 ns period
`define ALERT_PULSE_NS 40
`define CLK_PERIOD_NS 10
`define ALERT_PULSE_CYC ((`ALERT_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- core/cfg_regs_pkg.sv
package cfg_regs_pkg;

    // decoded mode settings handed to the rest of the controller
    typedef struct packed {
        logic transceivers_reset;
        logic overcurrent_detect_type;
        logic bus_is_32bit;
        logic dma_ack_polarity;
        logic dma_request_polarity;
        logic alert_polarity;
        logic alert_signalling_style;
        logic alert_master_gate;
    } mode_cfg_t;

    // apb request bundle
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    // alert shaper states
    typedef enum logic [2:0] {
        AL_IDLE = 3'b001,
        AL_PULSE = 3'b010,
        AL_WAIT = 3'b100
    } alert_state_t;

endpackage

//--- core/alert_shaper.sv
`timescale 1ns/100ps
`include "cfg_regs_defs.svh"

// turns the internal event level into the alert pin, per polarity and style
module alert_shaper
    import cfg_regs_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // settings and event
    input wire logic gate,
    input wire logic style_edge,
    input wire logic pol_high,
    input wire logic event_level,
    // pin
    output logic alert_out
);
    import cfg_regs_pkg::*;

    alert_state_t state_reg, state_next; // shaper state
    logic [3:0] cnt_reg, cnt_next; // pulse width counter
    logic out_reg, out_next; // alert pin
    logic active; // asserted meaning, before polarity

    // next state of the shaper
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        active = 1'b0;
        case (state_reg)
            AL_IDLE: begin
                if (gate && event_level && style_edge) begin
                    state_next = AL_PULSE;
                    cnt_next = 4'(`ALERT_PULSE_CYC - 1);
                end
            end
            AL_PULSE: begin
                active = 1'b1;
                if (!gate) begin
                    state_next = AL_IDLE; // gate closes pulse too
                end else if (cnt_reg == 4'h0) begin
                    state_next = AL_WAIT;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            AL_WAIT: begin
                // one pulse per event: wait for the event to drop
                if (!event_level || !gate) begin
                    state_next = AL_IDLE;
                end
            end
            default: begin
                state_next = AL_IDLE;
            end
        endcase
        if (!style_edge) begin
            active = event_level; // level style
        end
        active = active && gate;
        out_next = pol_high ? active : ~active;
    end

    // register state and pin
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= AL_IDLE;
            cnt_reg <= 4'h0;
            // inactive level for the reset sense (low active, gate closed)
            out_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            out_reg <= out_next;
        end
    end

    assign alert_out = out_reg;

    // edge style gives exactly the fixed pulse width
    a_pulse_width: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $rose(state_reg == AL_PULSE) && gate |-> (state_reg == AL_PULSE)[*4])
        else $error("alert pulse width wrong");
endmodule

//--- core/cfg_regs.sv
// Our own choice: register access over APB.
`timescale 1ns/100ps
`include "cfg_regs_defs.svh"

module cfg_regs
    import cfg_regs_pkg::*;
#(
    // identification halves, values arbitrary
    parameter logic [15:0] HW_VERSION = 16'h00A5,
    parameter logic [15:0] IDENTIFICATION_VALUE = 16'h5A00
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // controller side
    input wire logic alert_event,
    input wire logic dma_request_int,
    input wire logic dma_ack_input,
    input wire logic port1_overcurrent_in,
    input wire logic port2_overcurrent_in,
    input wire logic port3_overcurrent_in,
    // pins and settings out
    output logic alert_out,
    output logic dma_request_output,
    output logic dma_ack_seen,
    output logic [2:0] overcurrent_seen,
    output logic port_transceiver_reset,
    output logic overcurrent_detect_type,
    output logic bus_is_32bit,
    output logic controller_regs_reset
);
    import cfg_regs_pkg::*;

    apb_req_t req; // bundled request
    logic [31:0] mode_reg, mode_next; // hardware mode control
    logic [31:0] scratch_reg, scratch_next; // scratch word
    logic [31:0] swrst_reg, swrst_next; // software reset control
    logic [31:0] prdata_reg, prdata_next; // read data
    logic pready_reg, pready_next; // access phase answer
    logic pslverr_reg, pslverr_next; // unmapped address flag
    logic req_reg, req_next; // dma request pin
    logic ack_reg, ack_next; // decoded dma acknowledge
    logic [2:0] oc_reg, oc_next; // decoded overcurrent
    logic hcrst_reg, hcrst_next; // controller reset pulse
    logic wr_en; // write taken this cycle
    logic rd_en; // read taken this cycle
    logic mapped; // address hits a register
    logic reset_all; // software full reset request
    mode_cfg_t cfg; // decoded settings
    logic alert_pin; // shaper output

    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

    // the access completes on the cycle pready is high
    assign wr_en = req.psel && req.penable && pready_reg && req.pwrite;
    assign rd_en = req.psel && req.penable && pready_reg && !req.pwrite;
    assign mapped = (req.paddr == `OFS_MODE) || (req.paddr == `OFS_IDENT) ||
                    (req.paddr == `OFS_SCRATCH) || (req.paddr == `OFS_SWRST);
    assign reset_all = wr_en && (req.paddr == `OFS_SWRST) && req.pwdata[`SWRST_ALL];

    // register writes and software resets
    always_comb begin
        mode_next = mode_reg;
        scratch_next = scratch_reg;
        swrst_next = swrst_reg;
        if (wr_en) begin
            case (req.paddr)
                `OFS_MODE: begin
                    mode_next = req.pwdata;
                end
                `OFS_SCRATCH: begin
                    scratch_next = req.pwdata;
                end
                `OFS_SWRST: begin
                    swrst_next = req.pwdata;
                end
                default: begin
                    // identification word and holes: no state change
                end
            endcase
        end
        if (reset_all) begin
            // full reset returns every register here to reset
            mode_next = `MODE_RESET;
            scratch_next = `SCRATCH_RESET;
            swrst_next = `SWRST_RESET;
        end
    end

    // apb answer: no wait state, read data latched at setup
    always_comb begin
        pready_next = req.psel && !req.penable;
        pslverr_next = req.psel && !req.penable && !mapped;
        prdata_next = prdata_reg;
        if (req.psel && !req.penable) begin
            case (req.paddr)
                `OFS_MODE: prdata_next = mode_reg;
                `OFS_IDENT: prdata_next = {HW_VERSION, IDENTIFICATION_VALUE};
                `OFS_SCRATCH: prdata_next = scratch_reg;
                `OFS_SWRST: prdata_next = swrst_reg;
                default: prdata_next = 32'h0000_0000;
            endcase
        end
    end

    // decoded settings
    always_comb begin
        cfg.transceivers_reset = mode_reg[`MODE_XCVR_RST];
        cfg.overcurrent_detect_type = mode_reg[`MODE_OC_TYPE];
        cfg.bus_is_32bit = mode_reg[`MODE_BUS_WIDTH];
        cfg.dma_ack_polarity = mode_reg[`MODE_ACK_POL];
        cfg.dma_request_polarity = mode_reg[`MODE_REQ_POL];
        cfg.alert_polarity = mode_reg[`MODE_ALERT_POL];
        cfg.alert_signalling_style = mode_reg[`MODE_ALERT_STYLE];
        cfg.alert_master_gate = mode_reg[`MODE_ALERT_GATE];
    end

    // pin polarity handling
    always_comb begin
        // request pin sense
        req_next = cfg.dma_request_polarity ? dma_request_int : ~dma_request_int;
        // acknowledge sense
        ack_next = cfg.dma_ack_polarity ? dma_ack_input : ~dma_ack_input;
        // pins are active low; analog type flips the comparator sense
        oc_next = cfg.overcurrent_detect_type ?
            {port3_overcurrent_in, port2_overcurrent_in, port1_overcurrent_in} :
            ~{port3_overcurrent_in, port2_overcurrent_in, port1_overcurrent_in};
        // controller register reset pulses on a write of bit 1
        hcrst_next = wr_en && (req.paddr == `OFS_SWRST) && req.pwdata[`SWRST_CTRL];
    end

    // registers
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_reg <= `MODE_RESET;
            scratch_reg <= `SCRATCH_RESET;
            swrst_reg <= `SWRST_RESET;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            req_reg <= 1'b0;
            ack_reg <= 1'b0;
            oc_reg <= 3'h0;
            hcrst_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            scratch_reg <= scratch_next;
            swrst_reg <= swrst_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            req_reg <= req_next;
            ack_reg <= ack_next;
            oc_reg <= oc_next;
            hcrst_reg <= hcrst_next;
        end
    end

    // alert pin generator
    alert_shaper u_alert (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .gate(cfg.alert_master_gate),
        .style_edge(cfg.alert_signalling_style),
        .pol_high(cfg.alert_polarity),
        .event_level(alert_event),
        .alert_out(alert_pin)
    );

    // outputs straight from flops
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign alert_out = alert_pin;
    assign dma_request_output = req_reg;
    assign dma_ack_seen = ack_reg;
    assign overcurrent_seen = oc_reg;
    assign port_transceiver_reset = mode_reg[`MODE_XCVR_RST];
    assign overcurrent_detect_type = mode_reg[`MODE_OC_TYPE];
    assign bus_is_32bit = mode_reg[`MODE_BUS_WIDTH];
    assign controller_regs_reset = hcrst_reg;

    // scratch holds the written word
    a_scratch_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wr_en && paddr == `OFS_SCRATCH && !reset_all |=> scratch_reg == $past(pwdata))
        else $error("scratch did not take write");
    // identification writes change nothing
    a_ident_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wr_en && paddr == `OFS_IDENT |=> $stable(mode_reg) && $stable(scratch_reg))
        else $error("ident write changed state");
    // identification read value
    a_ident_read: assert property (@(posedge ref_clk) disable iff (!rst_b)
        psel && !penable && paddr == `OFS_IDENT |=> prdata == {HW_VERSION, IDENTIFICATION_VALUE})
        else $error("ident read wrong");
    // gate closed keeps alert inactive
    a_gate_closed: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !mode_reg[0] && $past(!mode_reg[0]) |=> alert_out == ~$past(mode_reg[2]))
        else $error("alert asserted with gate closed");
    // level style follows event
    a_level_alert: assert property (@(posedge ref_clk) disable iff (!rst_b)
        mode_reg[0] && !mode_reg[1] && alert_event && $stable(mode_reg)
        |=> alert_out == $past(mode_reg[2]))
        else $error("level alert missing");
    // request pin sense
    a_req_sense: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $stable(mode_reg) |=>
        dma_request_output == ($past(dma_request_int) ~^ $past(mode_reg[5])))
        else $error("dma request sense wrong");
    // acknowledge sense
    a_ack_sense: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $stable(mode_reg) |=>
        dma_ack_seen == ($past(dma_ack_input) ~^ $past(mode_reg[6])))
        else $error("dma ack sense wrong");
    // full reset clears scratch
    a_reset_all: assert property (@(posedge ref_clk) disable iff (!rst_b)
        reset_all |=> scratch_reg == 32'h0000_0000 && mode_reg == `MODE_RESET)
        else $error("full reset incomplete");

    c_scratch_wr: cover property (@(posedge ref_clk) wr_en && paddr == `OFS_SCRATCH);
    c_edge_alert: cover property (@(posedge ref_clk) mode_reg[1:0] == 2'b11 && alert_event);
    c_reset_all: cover property (@(posedge ref_clk) reset_all);
endmodule

//--- verification/apb_host_model.sv
`timescale 1ns/100ps
`include "cfg_regs_defs.svh"

// apb master standing in for the embedded processor
module apb_host_model (
    // clock
    input wire logic ref_clk,
    // apb request and answer
    output cfg_regs_pkg::apb_req_t req,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    import cfg_regs_pkg::*;

    // idle bus from time zero
    initial req = '0;

    // one whole transfer, entered just after a rising edge
    task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic err);
        logic [31:0] d;
        int n;
        d = wdata;
        // reserved mode bits always go out as zero
        if (wr && addr == `OFS_MODE) d = d & 32'h8000_8167;
        // reserved reset bits always go out as zero
        if (wr && addr == `OFS_SWRST) d = d & 32'h0000_0003;
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: d};
        @(posedge ref_clk);
        req.penable <= 1'b1;
        n = 0;
        // look at pready mid-cycle, where it is settled; the bench watchdog ends a hang
        do begin
            @(negedge ref_clk);
            n++;
        end while (pready !== 1'b1);
        // answer stands through this cycle and is taken for the closing edge
        rdata = prdata;
        err = pslverr;
        @(posedge ref_clk);
        // release, with stale write data scrambled
        req <= '{psel: 1'b0, penable: 1'b0, pwrite: 1'b0, paddr: ~addr, pwdata: ~d};
        @(posedge ref_clk);
    endtask
endmodule

//--- verification/testbench.sv
`timescale 1ns/100ps
`include "cfg_regs_defs.svh"

// register bench: bus tasks plus pin stimulus
module testbench;
    import cfg_regs_pkg::*;

    localparam logic [15:0] ID_HI = 16'h00C3; // arbitrary version value
    localparam logic [15:0] ID_LO = 16'h3C00; // arbitrary identifier value

    logic ref_clk, rst_b, alert_event, dma_request_int, dma_ack_input;
    logic [2:0] oc_pins;
    apb_req_t req;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, alert_out, dma_request_output, dma_ack_seen;
    wire logic [2:0] overcurrent_seen;
    wire logic port_transceiver_reset, overcurrent_detect_type, bus_is_32bit;
    wire logic controller_regs_reset;
    int failures = 0;
    int checks_done = 0;
    int pulses = 0; // controller reset pulses seen
    logic [31:0] rd;
    logic er;
    int n, p0;

    // processor model
    apb_host_model i_host (.ref_clk(ref_clk), .req(req), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    cfg_regs #(.HW_VERSION(ID_HI), .IDENTIFICATION_VALUE(ID_LO)) i_dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .psel(req.psel), .penable(req.penable),
        .pwrite(req.pwrite), .paddr(req.paddr), .pwdata(req.pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .alert_event(alert_event),
        .dma_request_int(dma_request_int), .dma_ack_input(dma_ack_input),
        .port1_overcurrent_in(oc_pins[0]), .port2_overcurrent_in(oc_pins[1]),
        .port3_overcurrent_in(oc_pins[2]), .alert_out(alert_out),
        .dma_request_output(dma_request_output), .dma_ack_seen(dma_ack_seen),
        .overcurrent_seen(overcurrent_seen), .port_transceiver_reset(port_transceiver_reset),
        .overcurrent_detect_type(overcurrent_detect_type), .bus_is_32bit(bus_is_32bit),
        .controller_regs_reset(controller_regs_reset));

    // 100 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // count controller reset pulses
    always @(negedge ref_clk) begin
        if (controller_regs_reset === 1'b1) pulses <= pulses + 1;
    end

    // verdict and end of run
    task automatic test_done();
        if (failures == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // compare one value
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // register write, answer ignored
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        i_host.xfer(1'b1, a, v, rd, er);
    endtask

    // register read with expected data and error flag
    task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp,
                          input logic exp_err);
        i_host.xfer(1'b0, a, 32'h0000_0000, rd, er);
        check(name, rd, exp);
        check({name, "_err"}, {31'h0, er}, {31'h0, exp_err});
    endtask

    // wait a few edges for registered pins to follow
    task automatic settle();
        repeat (3) @(posedge ref_clk);
    endtask

    // watchdog far beyond the expected run
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        test_done();
    end

    // main sequence
    initial begin
        rst_b = 1'b0;
        alert_event = 1'b0;
        dma_request_int = 1'b0;
        dma_ack_input = 1'b0;
        oc_pins = 3'b000;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        // gate closed at reset: pin sits inactive, low-active sense
        check("alert_reset", {31'h0, alert_out}, 32'h1);
        // reset values and identification
        rd_chk("mode", `OFS_MODE, `MODE_RESET, 1'b0);
        rd_chk("scratch", `OFS_SCRATCH, 32'h0000_0000, 1'b0);
        rd_chk("swrst", `OFS_SWRST, 32'h0000_0000, 1'b0);
        rd_chk("ident", `OFS_IDENT, {ID_HI, ID_LO}, 1'b0);
        // scratch patterns and ignored identification write
        wr(`OFS_SCRATCH, 32'hFFFF_FFFF);
        rd_chk("scratch", `OFS_SCRATCH, 32'hFFFF_FFFF, 1'b0);
        wr(`OFS_SCRATCH, 32'hA5C3_5A3C);
        wr(`OFS_IDENT, 32'hFFFF_FFFF);
        rd_chk("ident", `OFS_IDENT, {ID_HI, ID_LO}, 1'b0);
        rd_chk("scratch", `OFS_SCRATCH, 32'hA5C3_5A3C, 1'b0);
        // unmapped places
        rd_chk("unmapped", 12'h310, 32'h0000_0000, 1'b1);
        i_host.xfer(1'b1, 12'h2FC, 32'h1234_5678, rd, er);
        check("unmapped_wr_err", {31'h0, er}, 32'h0000_0001);
        // every mode field set, then cleared
        oc_pins <= 3'b101;
        wr(`OFS_MODE, 32'hFFFF_FFFF);
        settle();
        rd_chk("mode", `OFS_MODE, 32'h8000_8167, 1'b0);
        check("xcvr_rst", {31'h0, port_transceiver_reset}, 32'h1);
        check("oc_type", {31'h0, overcurrent_detect_type}, 32'h1);
        check("oc_seen", {29'h0, overcurrent_seen}, 32'h5);
        check("bus32", {31'h0, bus_is_32bit}, 32'h1);
        wr(`OFS_MODE, 32'h0000_0000);
        settle();
        check("xcvr_rst", {31'h0, port_transceiver_reset}, 32'h0);
        check("oc_seen", {29'h0, overcurrent_seen}, 32'h2);
        check("bus32", {31'h0, bus_is_32bit}, 32'h0);
        // dma senses
        for (int p = 0; p < 2; p++) begin
            wr(`OFS_MODE, {25'h0, p[0], p[0], 5'h0});
            for (int v = 0; v < 2; v++) begin
                dma_request_int <= v[0];
                dma_ack_input <= v[0];
                settle();
                check("dma_req", {31'h0, dma_request_output}, {31'h0, ~(p[0] ^ v[0])});
                check("dma_ack", {31'h0, dma_ack_seen}, {31'h0, ~(p[0] ^ v[0])});
            end
        end
        // alert pin in level style, gate off and on, both senses
        for (int p = 0; p < 2; p++) begin
            for (int g = 0; g < 2; g++) begin
                wr(`OFS_MODE, {29'h0, p[0], 1'b0, g[0]});
                alert_event <= 1'b1;
                settle();
                check("alert_on", {31'h0, alert_out}, {31'h0, ~(p[0] ^ g[0])});
                alert_event <= 1'b0;
                settle();
                check("alert_off", {31'h0, alert_out}, {31'h0, ~p[0]});
            end
            // edge style: one fixed pulse while the event stays high
            wr(`OFS_MODE, {29'h0, p[0], 2'b11});
            alert_event <= 1'b1;
            n = 0;
            repeat (12) begin
                @(negedge ref_clk);
                if (alert_out === p[0]) n++;
            end
            check("pulse_len", n, `ALERT_PULSE_CYC);
            alert_event <= 1'b0;
            settle();
        end
        // software resets
        wr(`OFS_MODE, 32'h0000_8004);
        p0 = pulses;
        wr(`OFS_SWRST, 32'h0000_0000);
        settle();
        check("no_pulse", pulses - p0, 32'h0);
        wr(`OFS_SWRST, 32'hFFFF_FFFE);
        settle();
        check("ctrl_pulse", pulses - p0, 32'h1);
        rd_chk("scratch", `OFS_SCRATCH, 32'hA5C3_5A3C, 1'b0);
        wr(`OFS_SWRST, 32'h0000_0001);
        rd_chk("mode", `OFS_MODE, `MODE_RESET, 1'b0);
        rd_chk("scratch", `OFS_SCRATCH, 32'h0000_0000, 1'b0);
        rd_chk("swrst", `OFS_SWRST, 32'h0000_0000, 1'b0);
        test_done();
    end
endmodule
